/* File: shared/sdcr_consts.svh */
// Constants of the synthesizer divider configuration registers.
// Assumes inclusion by bare name from the package and design files.
`ifndef SDCR_CONSTS_SVH
`define SDCR_CONSTS_SVH

// ----------------------------------------------------------------------
// Destination select codes (low three bits of each serial word)
// ----------------------------------------------------------------------
`define SDCR_SEL_HI 2
`define SDCR_SEL_LO 0
`define SDCR_SEL_INT_MSB 3'h0
`define SDCR_SEL_LSB_SUBUNIT_DIVIDE_VALUE 3'h1
`define SDCR_SEL_REF_DIV 3'h2

// ----------------------------------------------------------------------
// Integer/MSB-fraction word fields
// ----------------------------------------------------------------------
`define SDCR_RAMP_ON_BIT 31
`define SDCR_MUX_HI 30
`define SDCR_MUX_LO 27
`define SDCR_INT_HI 26
`define SDCR_INT_LO 15
`define SDCR_FMSB_HI 14
`define SDCR_FMSB_LO 3

// ----------------------------------------------------------------------
// LSB-fraction word fields
// ----------------------------------------------------------------------
`define SDCR_FLSB_HI 27
`define SDCR_FLSB_LO 15
`define SDCR_FLSB_W 13

// ----------------------------------------------------------------------
// Reference-divider word fields
// ----------------------------------------------------------------------
`define SDCR_CSR_BIT 28
`define SDCR_CP_HI 27
`define SDCR_CP_LO 24
`define SDCR_PRESC_BIT 22
`define SDCR_HALVER_BIT 21
`define SDCR_DOUBLER_BIT 20
`define SDCR_RCNT_HI 19
`define SDCR_RCNT_LO 15
`define SDCR_STEP_HI 14
`define SDCR_STEP_LO 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SDCR_RST_WORD 32'h0000_0000
`define SDCR_RST_FLSB 13'h0000

`endif

/* File: shared/sdcr_pkg.sv */
// Types shared by the synthesizer divider configuration registers.
// Assumes the constants header sits beside it on the include path.
package sdcr_pkg;
  `include "sdcr_consts.svh"

  // Serial word as shifted in
  typedef logic [31:0] sdcr_word_t;
  // Destination select code
  typedef logic [2:0] sdcr_sel_t;
  // Composed fraction word for the interpolator
  typedef logic [24:0] sdcr_subunit_divide_value_t;
endpackage : sdcr_pkg

/* File: rtl/sdcr_prog_div.sv */
// Programmable tick divider: one output pulse per ratio input ticks.
// Assumes i_tick is a one-cycle pulse in the i_ref_clk domain.
`timescale 1ns/1ps
module sdcr_prog_div #(
  parameter int W = 5
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Ticks and ratio (zero means two to the W)
  input wire logic i_tick,
  input wire logic [W-1:0] i_ratio,
  output logic o_tick_ff
);

  logic [W-1:0] count_ff;
  logic [W-1:0] last;

  // Terminal count for the programmed ratio
  always_comb begin
    if (i_ratio == '0) begin
      last = '1;
    end else begin
      last = i_ratio - W'(1);
    end
  end

  // Count input ticks, wrap at the terminal count
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      count_ff <= '0;
    end else if (i_tick) begin
      if (count_ff >= last) begin
        count_ff <= '0;
      end else begin
        count_ff <= count_ff + W'(1);
      end
    end
  end

  // Output pulse on the wrapping tick
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_tick_ff <= 1'b0;
    end else begin
      o_tick_ff <= i_tick && (count_ff >= last);
    end
  end

endmodule : sdcr_prog_div

/* File: rtl/sdcr_regs.sv */
// Serial-loaded configuration registers of a fractional-N synthesizer,
// with reference path (doubler, counter, halver) and ramp step timer.
// Assumes serial pins and reference input are synchronous to i_ref_clk.
//
// Functional notes
// - Low three bits pick destination word
// - Bit 31 turns ramp on
// - Bits 30..27 pick test output source
// - Twelve-bit integer division part
// - Fraction MSB 14..3, LSB 27..15
// - Fraction equals LSB plus MSB times 8192
// - LSB fraction is held in buffer
// - Cycle slip reduction bit enables feature
// - Bits 27..24 hold charge pump code
// - Bit 21 adds divide-by-two halver stage
// - Bit 20 doubles reference before counter
// - Active edges: falling, or both doubled
// - Reference counter divides by 1..32
// - Bits 14..3 set ramp step divider
`timescale 1ns/1ps
`include "sdcr_consts.svh"
module sdcr_regs
  import sdcr_pkg::*;
#(
  parameter int RCNT_W = 5,
  parameter int STEP_W = 12
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Three-wire serial port
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_load_en,
  // Reference input
  input wire logic i_reference_input,
  // Integer/MSB-fraction settings
  output logic o_ramp_enable_ff,
  output logic [3:0] o_multiplexed_test_output_sel_ff,
  output logic [11:0] o_integer_ff,
  output sdcr_subunit_divide_value_t o_subunit_divide_value_ff,
  output logic o_subunit_divide_value_load_ff,
  // Reference-divider settings
  output logic o_cycle_slip_reduction_ff,
  output logic [3:0] o_cp_current_ff,
  output logic o_prescaler_sel_ff,
  output logic o_reference_halver_ff,
  output logic o_reference_doubler_ff,
  output logic [RCNT_W-1:0] o_ref_count_ff,
  output logic [STEP_W-1:0] o_ramp_step_timer_ff,
  // Reference path and ramp timing
  output logic o_pfd_tick_ff,
  output logic o_pfd_half_ff,
  output logic o_ramp_step_ff
);

  // --------------------------------------------------------------------
  // Serial port capture
  // --------------------------------------------------------------------
  sdcr_word_t shift_ff;
  logic ser_clk_d_ff;
  logic load_en_d_ff;
  logic ser_rise;
  logic load_rise;
  sdcr_sel_t sel;
  logic wr_int;
  logic wr_lsb;
  logic wr_ref;
  logic [`SDCR_FLSB_W-1:0] lsb_buf_ff;

  // Edge detection of serial clock and load enable
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      ser_clk_d_ff <= 1'b0;
      load_en_d_ff <= 1'b0;
    end else begin
      ser_clk_d_ff <= i_ser_clk;
      load_en_d_ff <= i_load_en;
    end
  end

  assign ser_rise = i_ser_clk && !ser_clk_d_ff;
  assign load_rise = i_load_en && !load_en_d_ff;

  // Data shifts in MSB first on each serial clock rise while load enable is low
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      shift_ff <= `SDCR_RST_WORD;
    end else if (ser_rise && !i_load_en) begin
      shift_ff <= {shift_ff[30:0], i_ser_data};
    end
  end

  // Destination decode on load enable rise
  assign sel = shift_ff[`SDCR_SEL_HI:`SDCR_SEL_LO];
  assign wr_int = load_rise && (sel == `SDCR_SEL_INT_MSB);
  assign wr_lsb = load_rise && (sel == `SDCR_SEL_LSB_SUBUNIT_DIVIDE_VALUE);
  assign wr_ref = load_rise && (sel == `SDCR_SEL_REF_DIV);

  // --------------------------------------------------------------------
  // Integer/MSB-fraction word and buffered LSB fraction
  // --------------------------------------------------------------------
  // Buffered LSB waits for the next integer word
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      lsb_buf_ff <= `SDCR_RST_FLSB;
    end else if (wr_lsb) begin
      lsb_buf_ff <= shift_ff[`SDCR_FLSB_HI:`SDCR_FLSB_LO];
    end
  end

  // Integer word loads all fields and the composed fraction
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_ramp_enable_ff <= 1'b0;
      o_multiplexed_test_output_sel_ff <= 4'h0;
      o_integer_ff <= 12'h000;
      o_subunit_divide_value_ff <= '0;
    end else if (wr_int) begin
      o_ramp_enable_ff <= shift_ff[`SDCR_RAMP_ON_BIT];
      o_multiplexed_test_output_sel_ff <= shift_ff[`SDCR_MUX_HI:`SDCR_MUX_LO];
      o_integer_ff <= shift_ff[`SDCR_INT_HI:`SDCR_INT_LO];
      // MSB times 8192 plus LSB is a plain concatenation
      o_subunit_divide_value_ff <= {shift_ff[`SDCR_FMSB_HI:`SDCR_FMSB_LO],
                                    lsb_buf_ff};
    end
  end

  // Strobe to the interpolator that a new value is active
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_subunit_divide_value_load_ff <= 1'b0;
    end else begin
      o_subunit_divide_value_load_ff <= wr_int;
    end
  end

  // --------------------------------------------------------------------
  // Reference-divider word
  // --------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_cycle_slip_reduction_ff <= 1'b0;
      o_cp_current_ff <= 4'h0;
      o_prescaler_sel_ff <= 1'b0;
      o_reference_halver_ff <= 1'b0;
      o_reference_doubler_ff <= 1'b0;
      o_ref_count_ff <= '0;
      o_ramp_step_timer_ff <= '0;
    end else if (wr_ref) begin
      o_cycle_slip_reduction_ff <= shift_ff[`SDCR_CSR_BIT];
      o_cp_current_ff <= shift_ff[`SDCR_CP_HI:`SDCR_CP_LO];
      o_prescaler_sel_ff <= shift_ff[`SDCR_PRESC_BIT];
      o_reference_halver_ff <= shift_ff[`SDCR_HALVER_BIT];
      o_reference_doubler_ff <= shift_ff[`SDCR_DOUBLER_BIT];
      o_ref_count_ff <= shift_ff[`SDCR_RCNT_HI:`SDCR_RCNT_LO];
      o_ramp_step_timer_ff <= shift_ff[`SDCR_STEP_HI:`SDCR_STEP_LO];
    end
  end

  // --------------------------------------------------------------------
  // Reference path: edge select, counter, halver
  // --------------------------------------------------------------------
  logic ref_d_ff;
  logic ref_rise;
  logic ref_fall;
  logic ref_tick;
  logic r_tick;
  logic pfd_tick;

  // Previous reference level for edge detection
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      ref_d_ff <= 1'b0;
    end else begin
      ref_d_ff <= i_reference_input;
    end
  end

  assign ref_rise = i_reference_input && !ref_d_ff;
  assign ref_fall = !i_reference_input && ref_d_ff;
  // Falling edge only, or both edges when doubled
  assign ref_tick = o_reference_doubler_ff ?
                    (ref_rise || ref_fall) : ref_fall;

  // Reference counter, code zero divides by 32
  sdcr_prog_div #(
    .W(RCNT_W)
  ) u_ref_count (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_tick(ref_tick),
    .i_ratio(o_ref_count_ff),
    .o_tick_ff(r_tick)
  );

  // Toggle stage for 50% duty at the detector
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_pfd_half_ff <= 1'b0;
    end else if (r_tick) begin
      o_pfd_half_ff <= !o_pfd_half_ff;
    end
  end

  assign pfd_tick = o_reference_halver_ff ? (r_tick && o_pfd_half_ff) : r_tick;

  // Registered detector reference tick
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_pfd_tick_ff <= 1'b0;
    end else begin
      o_pfd_tick_ff <= pfd_tick;
    end
  end

  // --------------------------------------------------------------------
  // Ramp step timer, counts detector ticks while ramp is on
  // --------------------------------------------------------------------
  sdcr_prog_div #(
    .W(STEP_W)
  ) u_step_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_tick(o_pfd_tick_ff && o_ramp_enable_ff),
    .i_ratio(o_ramp_step_timer_ff),
    .o_tick_ff(o_ramp_step_ff)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  logic [12:0] lsb_word_ff;

  // Separate copy of the last LSB word, for the apply check
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      lsb_word_ff <= 13'h0000;
    end else if (load_rise && (shift_ff[2:0] == 3'h1)) begin
      lsb_word_ff <= shift_ff[27:15];
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  int_load_a: assert property (wr_int |=> o_integer_ff == $past(shift_ff[26:15]))
    else $error("integer field not loaded");
  ramp_load_a: assert property (wr_int |=> o_ramp_enable_ff == $past(shift_ff[31]))
    else $error("ramp bit not loaded");
  mux_load_a: assert property (wr_int |=>
    o_multiplexed_test_output_sel_ff == $past(shift_ff[30:27]))
    else $error("test output select not loaded");
  subunit_divide_value_join_a: assert property (wr_int |=>
    (o_subunit_divide_value_ff[24:13] == $past(shift_ff[14:3]))
    && (o_subunit_divide_value_ff[12:0] == $past(lsb_buf_ff)) && o_subunit_divide_value_load_ff)
    else $error("fraction composition wrong");
  lsb_held_a: assert property (wr_lsb |=> $stable(o_subunit_divide_value_ff)
    && (lsb_buf_ff == $past(shift_ff[27:15])))
    else $error("lsb fraction took effect at once");
  lsb_apply_a: assert property (wr_int |=>
    o_subunit_divide_value_ff[12:0] == $past(lsb_word_ff))
    else $error("buffered lsb not applied");
  sel_decode_a: assert property (load_rise && (shift_ff[2:0] > 3'h2) |=>
    $stable(o_integer_ff) && $stable(o_cp_current_ff) && $stable(lsb_buf_ff))
    else $error("unselected word changed a register");
  ref_word_a: assert property (wr_ref |=>
    (o_cp_current_ff == $past(shift_ff[27:24]))
    && (o_cycle_slip_reduction_ff == $past(shift_ff[28]))
    && (o_ramp_step_timer_ff == $past(shift_ff[14:3])))
    else $error("reference word fields wrong");
  edge_sel_a: assert property (!o_reference_doubler_ff && ref_rise |-> !ref_tick)
    else $error("rising edge active without doubler");
  halver_a: assert property (o_reference_halver_ff && r_tick && !o_pfd_half_ff |=>
    !o_pfd_tick_ff)
    else $error("halver passed every counter tick");
  rdiv_one_a: assert property (o_ref_count_ff == 5'h01 && ref_tick && !wr_ref |=> r_tick)
    else $error("divide by one missed a tick");

  int_cov_c: cover property (wr_int);
  lsb_cov_c: cover property (wr_lsb ##[1:200] wr_int);
  ref_cov_c: cover property (wr_ref);
  step_cov_c: cover property (o_ramp_step_ff);

endmodule : sdcr_regs

/* File: verif/sdcr_host_model.sv */
// Host model driving the three-wire serial load port.
// Assumes the block samples the pins on the rising edge of i_ref_clk.
`timescale 1ns/1ps
module sdcr_host_model
  import sdcr_pkg::*;
(
  // Clock
  input wire logic i_ref_clk,
  // Serial pins
  output logic o_ser_clk,
  output logic o_ser_data,
  output logic o_load_en
);
  // ----------------------------------------------------------------
  // Pin idle levels
  // ----------------------------------------------------------------
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_load_en = 1'b0;
  end

  // Shift 32 bits first bit = bit 31, then pulse load
  // Callers compose words for codes 0..2 with reserved bits zero
  task automatic send_word(input sdcr_word_t w);
    for (int i = 31; i >= 0; i--) begin
      @(negedge i_ref_clk);
      o_ser_data <= w[i];
      o_ser_clk <= 1'b1;
      @(negedge i_ref_clk);
      o_ser_clk <= 1'b0;
    end
    @(negedge i_ref_clk);
    o_load_en <= 1'b1;
    o_ser_data <= ~w[0]; // Stale data is not left on the line
    @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    o_load_en <= 1'b0;
    @(negedge i_ref_clk);
  endtask : send_word
endmodule : sdcr_host_model

/* File: verif/test_sdcr_regs.sv */
// Self-checking bench for the configuration registers.
// Assumes a 250 MHz i_ref_clk and the host model for serial loads.
`timescale 1ns/1ps
module test_sdcr_regs;
  import sdcr_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_reference_input = 1'b0;
  logic ser_clk, ser_data, load_en;
  logic ramp, halver, doubler, cycle_slip_reduction, presc, subunit_divide_value_load, pfd_tick, pfd_half, ramp_step;
  logic [3:0] mux, cp;
  logic [11:0] int_v, step;
  logic [4:0] rcnt;
  sdcr_subunit_divide_value_t subunit_divide_value;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0, pfd_last = 0, pfd_iv = 0, rmp_last = 0, rmp_iv = 0, n_load = 0;
  int half_last = 0, half_iv = 0;
  logic half_d = 1'b0;
  logic [1:0] rdiv = 2'h0;
  // Table: doubler, halver, csr, cp, ratio, pfd interval
  int tab [5][6] = '{'{0, 0, 0, 10, 3, 12}, '{1, 0, 0, 10, 3, 6}, '{0, 1, 1, 0, 3, 24},
    '{0, 0, 0, 10, 1, 4}, '{0, 0, 0, 10, 0, 128}};

  // ----------------------------------------------------------------
  // Clock, reference and monitors
  // ----------------------------------------------------------------
  always #2 i_ref_clk = ~i_ref_clk;
  // Reference of four clock periods
  always @(negedge i_ref_clk) begin
    rdiv <= rdiv + 2'h1;
    i_reference_input <= rdiv[1];
  end
  // Intervals between pulses
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (pfd_tick === 1'b1) begin
      pfd_iv <= cyc - pfd_last;
      pfd_last <= cyc;
    end
    if (ramp_step === 1'b1) begin
      rmp_iv <= cyc - rmp_last;
      rmp_last <= cyc;
    end
    if (subunit_divide_value_load === 1'b1) n_load <= n_load + 1;
    // Interval between rises of the halver toggle
    half_d <= pfd_half;
    if (pfd_half === 1'b1 && half_d === 1'b0) begin
      half_iv <= cyc - half_last;
      half_last <= cyc;
    end
  end

  sdcr_host_model u_sdcr_host_model (.i_ref_clk(i_ref_clk), .o_ser_clk(ser_clk),
    .o_ser_data(ser_data), .o_load_en(load_en));
  sdcr_regs u_sdcr_regs (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ser_clk(ser_clk),
    .i_ser_data(ser_data), .i_load_en(load_en), .i_reference_input(i_reference_input),
    .o_ramp_enable_ff(ramp), .o_multiplexed_test_output_sel_ff(mux), .o_integer_ff(int_v),
    .o_subunit_divide_value_ff(subunit_divide_value), .o_subunit_divide_value_load_ff(subunit_divide_value_load),
    .o_cycle_slip_reduction_ff(cycle_slip_reduction), .o_cp_current_ff(cp), .o_prescaler_sel_ff(presc),
    .o_reference_halver_ff(halver), .o_reference_doubler_ff(doubler),
    .o_ref_count_ff(rcnt), .o_ramp_step_timer_ff(step), .o_pfd_tick_ff(pfd_tick),
    .o_pfd_half_ff(pfd_half), .o_ramp_step_ff(ramp_step));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input sdcr_word_t w);
    u_sdcr_host_model.send_word(w);
    repeat (3) @(negedge i_ref_clk);
  endtask : wr

  task automatic complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // Watchdog
  initial begin
    #160000;
    n_fail++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(negedge i_ref_clk);
    check("rst_subunit_divide_value", subunit_divide_value, 32'h0);
    check("rst_int", {ramp, mux, int_v}, 32'h0);
    check("rst_ref", {cycle_slip_reduction, cp, presc, halver, doubler, rcnt, step}, 32'h0);
    // Buffered LSB does not act until next integer word
    wr({4'h0, 13'h1ABC, 12'h000, 3'h1});
    check("subunit_divide_value_buf", subunit_divide_value, 32'h0);
    // 291 keeps division above the 8/9 minimum
    wr({1'b1, 4'h9, 12'h123, 12'hFED, 3'h0});
    check("ramp", ramp, 32'h1);
    check("mux", mux, 32'h9);
    check("int", int_v, 32'h123);
    check("subunit_divide_value", subunit_divide_value, (32'hFED << 13) + 32'h1ABC);
    check("subunit_divide_value_load", n_load, 32'h1);
    wr({4'h0, 13'h1FFF, 12'h000, 3'h1});
    check("subunit_divide_value_hold", subunit_divide_value, (32'hFED << 13) + 32'h1ABC);
    wr({1'b1, 4'h9, 12'h123, 12'h001, 3'h0});
    check("subunit_divide_value_new", subunit_divide_value, 32'h2000 + 32'h1FFF);
    // Unused code changes nothing
    wr(32'hFFFF_FFFB);
    check("refused", {ramp, mux, int_v}, 32'h19123);
    // Reference path modes; slip reduction only with halver and least current
    foreach (tab[k]) begin
      wr({3'h0, tab[k][2][0], tab[k][3][3:0], 1'b0, 1'b1, tab[k][1][0], tab[k][0][0],
        tab[k][4][4:0], 12'h002, 3'h2});
      check("csr", cycle_slip_reduction, tab[k][2]);
      check("cp", cp, tab[k][3]);
      check("presc", presc, 32'h1);
      check("rcnt", rcnt, tab[k][4]);
      check("step", step, 32'h2);
      check("modes", {halver, doubler}, tab[k][1] * 2 + tab[k][0]);
      repeat (8 * tab[k][5] + 40) @(negedge i_ref_clk);
      check("pfd_iv", pfd_iv, tab[k][5]);
      check("ramp_iv", rmp_iv, 2 * tab[k][5]);
      check("half_iv", half_iv, (2 - tab[k][1]) * tab[k][5]);
    end
    complete_run();
  end
endmodule : test_sdcr_regs
